// >>> design/avs_audio_video_ctrl.sv
// APB register bank and select decoding for the audio/video switch.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module avs_audio_video_ctrl
	import avs_pkg::*;
#(
	parameter logic [3:0] DEVICE_ID = 4'h5 // Arbitrary identification value.
) (
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// APB slave.
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]     prdata,
	output logic            pready,
	output logic            pslverr,
	// Function pin comparators and fault sensors.
	input  wire logic [1:0] aux_function_sense,
	input  wire logic [1:0] tv_function_sense,
	input  wire logic       aux_function_gnd_short,
	input  wire logic       aux_function_ext_volt,
	input  wire logic       tv_function_gnd_short,
	input  wire logic       tv_function_ext_volt,
	// Function pin drivers.
	output logic            aux_function_drive_en,
	output logic [1:0]      aux_function_level,
	output logic            tv_function_drive_en,
	output logic [1:0]      tv_function_level,
	// Auxiliary video and audio selects.
	output logic [2:0]      aux_source_sel,
	output logic [2:0]      aux_svhs_format,
	output logic            aux_video_mute,
	output logic            aux_audio_from_tv,
	output logic [1:0]      aux_stereo_mode,
	output logic            aux_audio_mute,
	// TV audio selects.
	output logic [2:0]      tv_source_sel,
	output logic            tv_audio_from_aux,
	output logic [1:0]      tv_stereo_mode,
	output logic            vol_gain_6db,
	output logic [5:0]      vol_atten,
	output logic [1:0]      dac_gain,
	output logic            tv_scart_vol_bypass,
	output logic            line_vol_bypass,
	output logic            line_from_tv_input,
	output logic            mod_mono_vol_bypass,
	output logic            tv_audio_mute
);

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Level codes 10 and 11 both drive the 11 V level.
	function automatic logic [1:0] drive_level(input logic [1:0] code);
		drive_level = code[1] ? AVS_LVL_PERI : code;
	endfunction

	// A driven pin is released when its wire is forced against the drive.
	function automatic logic pin_fault(input logic [1:0] lvl,
			input logic gnd, input logic ext);
		pin_fault = (lvl != AVS_LVL_NORMAL) ? gnd : ext;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers and bus access.

	logic [7:0]   reg_volume;
	logic [7:0]   reg_av_ctrl;
	logic [7:0]   reg_video;
	logic [7:0]   reg_gain;
	logic [7:0]   reg_routing;
	logic [1:0]   status_level;
	logic         access_done;
	logic         addr_ok;
	logic [2:0]   reg_idx;

	assign reg_idx     = paddr[4:2];
	assign addr_ok     = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0)
		&& (reg_idx <= AVS_IDX_STATUS);
	assign access_done = psel && penable && pready;

	// One wait-free access: ready rises in the access phase only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable && !pready;
			pslverr <= psel && !penable && !pready && !addr_ok;
		end
	end

	// Read data is captured in the setup cycle so it stands from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite && addr_ok) begin
			unique case (reg_idx)
				AVS_IDX_VOLUME:  prdata <= {24'h00_0000, reg_volume};
				AVS_IDX_AV_CTRL: prdata <= {24'h00_0000, reg_av_ctrl};
				AVS_IDX_VIDEO:   prdata <= {24'h00_0000, reg_video};
				AVS_IDX_GAIN:    prdata <= {24'h00_0000, reg_gain};
				AVS_IDX_ROUTING: prdata <= {24'h00_0000, reg_routing};
				AVS_IDX_STATUS:  prdata <= {24'h00_0000, DEVICE_ID,
					2'h0, status_level};
				default:         prdata <= 32'h0000_0000;
			endcase
		end else if (psel && !penable) begin
			prdata <= 32'h0000_0000;
		end
	end

	// Writes land on the completing edge; the status word is read only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_volume  <= AVS_RST_VOLUME;
			reg_av_ctrl <= AVS_RST_AV_CTRL;
			reg_video   <= AVS_RST_VIDEO;
			reg_gain    <= AVS_RST_GAIN;
			reg_routing <= AVS_RST_ROUTING;
		end else if (access_done && pwrite && !pslverr) begin
			unique case (reg_idx)
				AVS_IDX_VOLUME:  reg_volume  <= pwdata[7:0];
				AVS_IDX_AV_CTRL: reg_av_ctrl <= pwdata[7:0];
				AVS_IDX_VIDEO:   reg_video   <= pwdata[7:0];
				AVS_IDX_GAIN:    reg_gain    <= pwdata[7:0];
				AVS_IDX_ROUTING: reg_routing <= pwdata[7:0];
				default:         reg_volume  <= reg_volume;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	logic [7:0]   sense_meta;
	logic [7:0]   sense_sync;
	logic [1:0]   aux_sense;
	logic [1:0]   tv_sense;

	// Comparator and fault levels are asynchronous to the bus clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sense_meta <= 8'h00;
			sense_sync <= 8'h00;
		end else begin
			sense_meta <= {aux_function_sense, tv_function_sense,
				aux_function_gnd_short, aux_function_ext_volt,
				tv_function_gnd_short, tv_function_ext_volt};
			sense_sync <= sense_meta;
		end
	end

	assign aux_sense = sense_sync[7:6];
	assign tv_sense  = sense_sync[5:4];

	////////////////////////////////////////////////////////////////////////
	// Function pin direction, level and pass-through.

	avs_dir_type  dir;
	avs_pass_type pass_state;
	avs_pass_type next_pass_state;
	logic [1:0]   own_level;
	logic         next_aux_en;
	logic         next_tv_en;
	logic [1:0]   next_aux_lvl;
	logic [1:0]   next_tv_lvl;

	assign dir       = avs_dir_type'(reg_video[AVS_FN_DIR_LSB +: 2]);
	assign own_level = drive_level(reg_video[AVS_FN_LEVEL_LSB +: 2]);

	// The driven side follows whichever pin first shows a non-normal level.
	always_comb begin
		next_pass_state = pass_state;
		unique case (pass_state)
			AVS_PASS_IDLE: begin
				if (aux_sense != AVS_LVL_NORMAL) begin
					next_pass_state = AVS_PASS_TO_TV;
				end else if (tv_sense != AVS_LVL_NORMAL) begin
					next_pass_state = AVS_PASS_TO_AUX;
				end
			end
			AVS_PASS_TO_TV: begin
				if (aux_sense == AVS_LVL_NORMAL) begin
					next_pass_state = AVS_PASS_IDLE;
				end
			end
			AVS_PASS_TO_AUX: begin
				if (tv_sense == AVS_LVL_NORMAL) begin
					next_pass_state = AVS_PASS_IDLE;
				end
			end
			default: next_pass_state = AVS_PASS_IDLE;
		endcase
		if (dir != AVS_DIR_PASS) begin
			next_pass_state = AVS_PASS_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pass_state <= AVS_PASS_IDLE;
		end else begin
			pass_state <= next_pass_state;
		end
	end

	// Drive plan per direction before fault release.
	always_comb begin
		next_aux_lvl = own_level;
		next_tv_lvl  = own_level;
		next_aux_en  = 1'b0;
		next_tv_en   = 1'b0;
		unique case (dir)
			AVS_DIR_BOTH_OUT: begin
				next_aux_en = 1'b1;
				next_tv_en  = 1'b1;
			end
			AVS_DIR_TV_IN:  next_aux_en = 1'b1;
			AVS_DIR_AUX_IN: next_tv_en  = 1'b1;
			AVS_DIR_PASS: begin
				next_tv_lvl  = aux_sense;
				next_aux_lvl = tv_sense;
				next_tv_en   = (pass_state == AVS_PASS_TO_TV);
				next_aux_en  = (pass_state == AVS_PASS_TO_AUX);
			end
		endcase
		if (pin_fault(next_aux_lvl, sense_sync[3], sense_sync[2])) begin
			next_aux_en = 1'b0;
		end
		if (pin_fault(next_tv_lvl, sense_sync[1], sense_sync[0])) begin
			next_tv_en = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_function_drive_en <= 1'b0;
			tv_function_drive_en  <= 1'b0;
			aux_function_level    <= AVS_LVL_NORMAL;
			tv_function_level     <= AVS_LVL_NORMAL;
		end else begin
			aux_function_drive_en <= next_aux_en;
			tv_function_drive_en  <= next_tv_en;
			aux_function_level    <= next_aux_lvl;
			tv_function_level     <= next_tv_lvl;
		end
	end

	// Sensed level of whichever pin is an input; zero in pass-through.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_level <= AVS_LVL_NORMAL;
		end else begin
			unique case (dir)
				AVS_DIR_TV_IN:  status_level <= tv_sense;
				AVS_DIR_AUX_IN: status_level <= aux_sense;
				default:        status_level <= AVS_LVL_NORMAL;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Audio and video select decoding.

	logic [2:0]   aux_code;
	logic [2:0]   tv_code;

	assign aux_code = reg_av_ctrl[AVS_AUX_SRC_LSB +: 3];
	assign tv_code  = reg_av_ctrl[AVS_TV_SRC_LSB +: 3];

	// Selects follow the stored fields one edge after the write lands.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_source_sel    <= AVS_AUX_MUTE;
			aux_svhs_format   <= 3'h0;
			aux_video_mute    <= 1'b1;
			aux_audio_from_tv <= 1'b0;
			tv_source_sel     <= 3'h7;
			tv_audio_from_aux <= 1'b1;
		end else begin
			aux_source_sel    <= aux_code;
			aux_video_mute    <= (aux_code == AVS_AUX_MUTE);
			aux_audio_from_tv <= (aux_code == AVS_AUX_COMP_TV)
				|| (aux_code == AVS_AUX_SVHS4);
			unique case (aux_code)
				AVS_AUX_SVHS1: aux_svhs_format <= 3'h1;
				AVS_AUX_SVHS2: aux_svhs_format <= 3'h2;
				AVS_AUX_SVHS3: aux_svhs_format <= 3'h3;
				AVS_AUX_SVHS4: aux_svhs_format <= 3'h4;
				default:       aux_svhs_format <= 3'h0;
			endcase
			tv_source_sel     <= tv_code;
			tv_audio_from_aux <= tv_code[0];
		end
	end

	// Gain, volume, routing and mute fields pass straight to the drivers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_stereo_mode     <= 2'h0;
			tv_stereo_mode      <= 2'h0;
			dac_gain            <= 2'h0;
			vol_gain_6db        <= 1'b0;
			vol_atten           <= 6'h00;
			tv_scart_vol_bypass <= 1'b0;
			line_vol_bypass     <= 1'b0;
			line_from_tv_input  <= 1'b0;
			mod_mono_vol_bypass <= 1'b0;
			tv_audio_mute       <= 1'b1;
			aux_audio_mute      <= 1'b1;
		end else begin
			aux_stereo_mode     <= reg_gain[AVS_AUX_MODE_LSB +: 2];
			tv_stereo_mode      <= reg_gain[AVS_TV_MODE_LSB +: 2];
			dac_gain            <= reg_gain[AVS_DAC_GAIN_LSB +: 2];
			vol_gain_6db        <= reg_routing[AVS_VOL_GAIN_BIT];
			vol_atten           <= reg_volume[5:0];
			tv_scart_vol_bypass <= reg_routing[AVS_SCART_BYP];
			line_vol_bypass     <= reg_routing[AVS_LINE_BYP];
			line_from_tv_input  <= reg_routing[AVS_LINE_TV_BIT];
			mod_mono_vol_bypass <= reg_routing[AVS_SCART_BYP];
			tv_audio_mute       <= reg_volume[AVS_TV_MUTE_BIT];
			aux_audio_mute      <= reg_volume[AVS_AUX_MUTE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_write_done;
		psel && penable && pready && pwrite && !pslverr;
	endsequence

	chk_tv_mute_follow: assert property (
		(s_write_done and (reg_idx == AVS_IDX_VOLUME))
		|-> ##2 tv_audio_mute == $past(pwdata[AVS_TV_MUTE_BIT], 2))
		else $error("TV mute does not follow volume write");

	chk_aux_mute_follow: assert property (
		(s_write_done and (reg_idx == AVS_IDX_VOLUME))
		|-> ##2 aux_audio_mute == $past(pwdata[AVS_AUX_MUTE_BIT], 2))
		else $error("Aux mute does not follow volume write");

	chk_aux_mute_code: assert property (
		aux_code == AVS_AUX_MUTE |=> aux_video_mute && !aux_audio_from_tv)
		else $error("Aux mute code not honoured");

	chk_svhs4_audio: assert property (
		aux_code == AVS_AUX_SVHS4 |=> aux_audio_from_tv
			&& aux_svhs_format == 3'h4)
		else $error("SVHS format 4 audio wrong");

	chk_same_level: assert property (
		dir == AVS_DIR_BOTH_OUT && $stable(dir) && $stable(reg_video)
		|=> aux_function_level == tv_function_level
			&& aux_function_level == drive_level($past(reg_video[1:0])))
		else $error("Output function levels differ");

	chk_fault_release: assert property (
		aux_function_drive_en && aux_function_level != AVS_LVL_NORMAL
		&& sense_sync[3] && $stable(reg_video) && dir != AVS_DIR_PASS
		|=> !aux_function_drive_en)
		else $error("Grounded aux function output kept driving");

	// A grounded TV pin driven at a non-normal level is released on the next edge.
	chk_tv_fault_release: assert property (
		tv_function_drive_en && tv_function_level != AVS_LVL_NORMAL
		&& sense_sync[1] && $stable(reg_video) && dir != AVS_DIR_PASS
		|=> !tv_function_drive_en)
		else $error("Grounded TV function output kept driving");

	chk_status_level: assert property (
		dir == AVS_DIR_TV_IN |=> status_level == $past(tv_sense))
		else $error("Sensed TV level not in status");

	chk_pass_drive: assert property (
		dir == AVS_DIR_PASS && pass_state == AVS_PASS_TO_TV
		|=> tv_function_level == $past(aux_sense) && !aux_function_drive_en)
		else $error("Pass-through not forwarding");

	chk_line_bypass: assert property (
		$stable(reg_routing) [*2] |-> line_vol_bypass == reg_routing[1]
			&& mod_mono_vol_bypass == reg_routing[AVS_SCART_BYP])
		else $error("Bypass selects out of step");

endmodule : avs_audio_video_ctrl

`default_nettype wire

// >>> design/avs_pkg.sv
// Constants and types shared by the audio/video control register block.
//
// Summary of operation
// - Auxiliary SVHS offers four encoder formats with fixed chroma/luma pin pairs.
// - Auxiliary SVHS formats 1-3 take DAC audio; format 4 takes TV SCART audio.
// - Auxiliary source field bits 3-5 resets 111: video 0 V, DAC audio.
// - Video control bits 2-3 set function pin directions; 11 is pass-through.
// - Pass-through forwards the level sensed on one function pin to the other.
// - An input function pin's sensed level sets read register bits 1-0.
// - Output function pin level: 00 is 0 V, 01 is 6 V, 1x is 11 V.
// - Two output function pins always carry the same level code.
// - Function output is disabled on short to ground or to a voltage source.
// - TV audio source follows the three low bits of the A/V control register.
// - Audio gain bits 4-5 pick TV stereo, sum, left-only or right-only.
// - Audio routing bit 2 sets volume amplifier gain 0 dB or 6 dB.
// - Audio volume bits 5-0 give 0 to -63 dB attenuation in 1 dB steps.
// - Audio gain bits 2-3 set DAC input gain 0, 6, 9 or 11.6 dB.
// - Audio routing bit 0 bypasses volume control on the TV SCART outputs.
// - Audio routing bit 1 bypasses volume control on the line outputs.
// - Audio routing bit 3 switches line outputs to the TV SCART inputs.
// - RF mono output sums TV SCART outputs after their volume bypass choice.
// - Audio volume bit 6 mutes all TV audio outputs; it resets high.
// - Auxiliary audio picks DAC or TV SCART inputs with the auxiliary video source.
// - Audio gain bits 6-7 pick auxiliary stereo, sum, left-only or right-only.
// - Audio volume bit 7 mutes all three auxiliary audio outputs; resets high.
// - Read register upper four bits hold a fixed device identification code.
// - In pass-through mode the sensed level bits of the read register are meaningless.

package avs_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [2:0] AVS_IDX_VOLUME  = 3'h0;
	localparam logic [2:0] AVS_IDX_AV_CTRL = 3'h1;
	localparam logic [2:0] AVS_IDX_VIDEO   = 3'h2;
	localparam logic [2:0] AVS_IDX_GAIN    = 3'h3;
	localparam logic [2:0] AVS_IDX_ROUTING = 3'h4;
	localparam logic [2:0] AVS_IDX_STATUS  = 3'h5;

	// Reset values.
	localparam logic [7:0] AVS_RST_VOLUME  = 8'hC0;
	localparam logic [7:0] AVS_RST_AV_CTRL = 8'h3F;
	localparam logic [7:0] AVS_RST_VIDEO   = 8'h00;
	localparam logic [7:0] AVS_RST_GAIN    = 8'h00;
	localparam logic [7:0] AVS_RST_ROUTING = 8'h00;

	// Field positions.
	localparam int AVS_TV_SRC_LSB   = 0;
	localparam int AVS_AUX_SRC_LSB  = 3;
	localparam int AVS_FN_LEVEL_LSB = 0;
	localparam int AVS_FN_DIR_LSB   = 2;
	localparam int AVS_DAC_GAIN_LSB = 2;
	localparam int AVS_TV_MODE_LSB  = 4;
	localparam int AVS_AUX_MODE_LSB = 6;
	localparam int AVS_TV_MUTE_BIT  = 6;
	localparam int AVS_AUX_MUTE_BIT = 7;
	localparam int AVS_SCART_BYP    = 0;
	localparam int AVS_LINE_BYP     = 1;
	localparam int AVS_VOL_GAIN_BIT = 2;
	localparam int AVS_LINE_TV_BIT  = 3;

	// Auxiliary source codes.
	localparam logic [2:0] AVS_AUX_COMP_TV = 3'h2;
	localparam logic [2:0] AVS_AUX_SVHS1   = 3'h3;
	localparam logic [2:0] AVS_AUX_SVHS2   = 3'h4;
	localparam logic [2:0] AVS_AUX_SVHS3   = 3'h5;
	localparam logic [2:0] AVS_AUX_SVHS4   = 3'h6;
	localparam logic [2:0] AVS_AUX_MUTE    = 3'h7;

	// Function pin levels: 00 is 0 V or normal, 01 is 6 V, 10 is 11 V.
	localparam logic [1:0] AVS_LVL_NORMAL = 2'h0;
	localparam logic [1:0] AVS_LVL_WIDE   = 2'h1;
	localparam logic [1:0] AVS_LVL_PERI   = 2'h2;

	// Function pin direction codes.
	typedef enum logic [1:0] {
		AVS_DIR_BOTH_OUT = 2'b00,
		AVS_DIR_TV_IN    = 2'b01,
		AVS_DIR_AUX_IN   = 2'b10,
		AVS_DIR_PASS     = 2'b11
	} avs_dir_type;

	// Pass-through flow states.
	typedef enum logic [1:0] {
		AVS_PASS_IDLE   = 2'b00,
		AVS_PASS_TO_TV  = 2'b01,
		AVS_PASS_TO_AUX = 2'b10
	} avs_pass_type;

endpackage : avs_pkg

// >>> tb/avs_audio_video_ctrl_tb.sv
// Self-checking bench for the audio/video switch register block.
`timescale 1ns/10ps
`default_nettype none

module avs_audio_video_ctrl_tb;
	// Identification value for this bench; it is arbitrary.
	localparam logic [3:0] ID = 4'h9;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  aux_function_sense, tv_function_sense, aux_ext, tv_ext;
	logic        aux_function_gnd_short, aux_function_ext_volt, aux_gnd;
	logic        tv_function_gnd_short, tv_function_ext_volt, tv_gnd;
	logic        aux_function_drive_en, tv_function_drive_en;
	logic [1:0]  aux_function_level, tv_function_level;
	logic [2:0]  aux_source_sel, aux_svhs_format, tv_source_sel;
	logic        aux_video_mute, aux_audio_from_tv, aux_audio_mute;
	logic [1:0]  aux_stereo_mode, tv_stereo_mode, dac_gain;
	logic        tv_audio_from_aux, vol_gain_6db, tv_scart_vol_bypass;
	logic        line_vol_bypass, line_from_tv_input, mod_mono_vol_bypass;
	logic        tv_audio_mute;
	logic [5:0]  vol_atten;
	int          errors, samples_checked, cycles;
	// Rows hold address, write data and the select view that must follow.
	logic [31:0] rows [26] = '{
		32'h0040_0080, 32'h0080_0040, 32'h001F_001F,
		32'h003F_003F, 32'h0020_0020,
		32'h0407_000F, 32'h040E_001C, 32'h0415_012B,
		32'h041C_0238, 32'h0423_0447, 32'h042A_0654,
		32'h0431_0963, 32'h0438_00F0,
		32'h0801_002D, 32'h0803_0036, 32'h0802_0036,
		32'h0800_0024,
		32'h0C6C_001B, 32'h0CB4_002D, 32'h0CD8_0036,
		32'h0C00_0000,
		32'h1001_0003, 32'h1002_0004, 32'h1004_0008,
		32'h1008_0010, 32'h1000_0000};
	logic [7:0]  rst [5] = '{8'hC0, 8'h3F, 8'h00, 8'h00, 8'h00};
	logic [15:0] rview [5] = '{16'h00C0, 16'h00FF, 16'h0024, 16'h0000,
		16'h0000};

	avs_audio_video_ctrl #(.DEVICE_ID(ID)) dut_u (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .aux_function_sense, .tv_function_sense,
		.aux_function_gnd_short, .aux_function_ext_volt,
		.tv_function_gnd_short, .tv_function_ext_volt,
		.aux_function_drive_en, .aux_function_level, .tv_function_drive_en,
		.tv_function_level, .aux_source_sel, .aux_svhs_format,
		.aux_video_mute, .aux_audio_from_tv, .aux_stereo_mode,
		.aux_audio_mute, .tv_source_sel, .tv_audio_from_aux,
		.tv_stereo_mode, .vol_gain_6db, .vol_atten, .dac_gain,
		.tv_scart_vol_bypass, .line_vol_bypass, .line_from_tv_input,
		.mod_mono_vol_bypass, .tv_audio_mute);

	avs_fn_pin_model fn_u (
		.aux_function_drive_en, .aux_function_level, .tv_function_drive_en,
		.tv_function_level, .aux_ext, .tv_ext, .aux_gnd, .tv_gnd,
		.aux_function_sense, .tv_function_sense, .aux_function_gnd_short,
		.tv_function_gnd_short, .aux_function_ext_volt,
		.tv_function_ext_volt);

	////////////////////////////////////////
	// Groups the selects that one register drives; an undriven pin's
	// level is masked because it means nothing.
	function automatic logic [15:0] view(input logic [7:0] a);
		case (a)
		8'h00: view = {8'h0, tv_audio_mute, aux_audio_mute, vol_atten};
		8'h04: view = {4'h0, aux_svhs_format, aux_audio_from_tv,
			aux_video_mute, aux_source_sel, tv_source_sel, tv_audio_from_aux};
		8'h08: view = {10'h0, aux_function_drive_en,
			aux_function_drive_en ? aux_function_level : 2'h0,
			tv_function_drive_en,
			tv_function_drive_en ? tv_function_level : 2'h0};
		8'h0C: view = {10'h0, aux_stereo_mode, tv_stereo_mode, dac_gain};
		default: view = {11'h0, line_from_tv_input, vol_gain_6db,
			line_vol_bypass, tv_scart_vol_bypass, mod_mono_vol_bypass};
		endcase
	endfunction

	// Compares one value; an unknown bit matches only an unknown bit in the same place on the other side.
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h, wanted %h", $time, seen, exp);
		end
	endtask

	// One APB transfer, entered just after a rising edge. The request is
	// left up so that a following call runs back to back; read data and
	// the error flag are taken at the edge that sees pready high.
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
	endtask

	// Releases the bus, lets selects and pin synchronisers catch up, then
	// compares away from the clock edge.
	task settle(input logic [7:0] a, input logic [15:0] exp);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (6) @(posedge pclk);
		@(negedge pclk);
		check(view(a), exp);
		@(posedge pclk);
	endtask

	// Sets a pin code, and only once our drivers have moved applies the
	// outside levels, so no false fault is raised on the way.
	task pins(input logic [7:0] d, input logic [1:0] ae, te,
		input logic [15:0] pv, input logic [1:0] st);
		aux_ext <= 2'h0;
		tv_ext <= 2'h0;
		apb(1'b1, 8'h08, d);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (3) @(posedge pclk);
		aux_ext <= ae;
		tv_ext <= te;
		settle(8'h08, pv);
		apb(1'b0, 8'h14, 8'h00);
		check(rd, {24'h0, ID, 2'h0, st});
	endtask

	// Prints the verdict and ends the run.
	task test_done();
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////
	// Free-running bus clock at 50 MHz.
	always #10 pclk = ~pclk;

	// Cuts the run short if a handshake never completes.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			test_done();
		end
	end

	// Defaults, the table of plain writes, then pins, faults, refused
	// accesses and a reset in mid-run.
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, aux_gnd, tv_gnd} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		{aux_ext, tv_ext} = 4'h0;
		errors = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'(4 * i), 8'h0);
			check(rd, {24'h0, rst[i]});
			settle(8'(4 * i), rview[i]);
		end
		apb(1'b0, 8'h14, 8'h0);
		check(rd, {24'h0, ID, 4'h0});
		foreach (rows[i]) begin
			apb(1'b1, rows[i][31:24], rows[i][23:16]);
			apb(1'b0, rows[i][31:24], 8'h0);
			check(rd, {24'h0, rows[i][23:16]});
			settle(rows[i][31:24], rows[i][15:0]);
		end
		// Code, outside levels, pins seen, sensed code read back.
		pins(8'h05, 2'h0, 2'h2, 16'h0028, 2'h2);
		pins(8'h05, 2'h0, 2'h1, 16'h0028, 2'h1);
		pins(8'h0A, 2'h1, 2'h0, 16'h0006, 2'h1);
		pins(8'h0C, 2'h2, 2'h0, 16'h0006, 2'h0);
		pins(8'h00, 2'h0, 2'h0, 16'h0024, 2'h0);
		pins(8'h0C, 2'h0, 2'h1, 16'h0028, 2'h0);
		pins(8'h00, 2'h1, 2'h0, 16'h0004, 2'h0);
		// Shorts to ground while driving 6 V must drop both drivers.
		apb(1'b1, 8'h08, 8'h01);
		aux_gnd <= 1'b1;
		tv_gnd <= 1'b1;
		settle(8'h08, 16'h0000);
		check(tv_function_drive_en, 1'b0);
		// Unmapped places answer with an error; the status ignores writes.
		apb(1'b1, 8'h18, 8'hFF);
		check(err, 1'b1);
		apb(1'b1, 8'h14, 8'h00);
		check(err, 1'b0);
		apb(1'b0, 8'h18, 8'h00);
		check(err, 1'b1);
		check(rd, 32'h0);
		apb(1'b0, 8'h14, 8'h00);
		check(rd[7:4], ID);
		// A reset in mid-run brings the mutes back.
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h00, 8'h0);
		check(rd, 32'hC0);
		settle(8'h00, 16'h00C0);
		test_done();
	end

endmodule // avs_audio_video_ctrl_tb

`default_nettype wire

// >>> tb/avs_fn_pin_model.sv
// Function pin model: pin loads, outside sources and fault sensors.
`timescale 1ns/10ps
`default_nettype none

module avs_fn_pin_model (
	// Device pin drivers.
	input  wire logic       aux_function_drive_en,
	input  wire logic [1:0] aux_function_level,
	input  wire logic       tv_function_drive_en,
	input  wire logic [1:0] tv_function_level,
	// Outside conditions from the bench; a source code of 00 means none.
	input  wire logic [1:0] aux_ext,
	input  wire logic [1:0] tv_ext,
	input  wire logic       aux_gnd,
	input  wire logic       tv_gnd,
	// Comparator codes and fault sensors towards the device.
	output logic [1:0]      aux_function_sense,
	output logic [1:0]      tv_function_sense,
	output logic            aux_function_gnd_short,
	output logic            tv_function_gnd_short,
	output logic            aux_function_ext_volt,
	output logic            tv_function_ext_volt
);
	////////////////////////////////////////
	// A short beats an outside source, which beats our own driver; an
	// undriven pin sinks to 0 V through its load.
	always_comb begin
		aux_function_sense = aux_gnd ? 2'h0 : (aux_ext != 2'h0) ? aux_ext
			: aux_function_drive_en ? aux_function_level : 2'h0;
		tv_function_sense = tv_gnd ? 2'h0 : (tv_ext != 2'h0) ? tv_ext
			: tv_function_drive_en ? tv_function_level : 2'h0;
	end

	// The sensors report the outside condition only; the device has to
	// weigh it against the level it drives.
	always_comb begin
		aux_function_gnd_short = aux_gnd;
		tv_function_gnd_short = tv_gnd;
		aux_function_ext_volt = aux_ext != 2'h0;
		tv_function_ext_volt = tv_ext != 2'h0;
	end

endmodule // avs_fn_pin_model

`default_nettype wire
